// [rtl/adm_dc_meas.sv]
// dc level meter of the mono adc channel: iir, sinc, result and read port
`default_nettype none
`include "adm_defines.svh"
module adm_dc_meas (
  input  wire logic                 mclk,
  input  wire logic                 reset_n,
  input  wire logic                 sample_valid,
  input  wire adm_pkg::adm_sample_t sample_data,
  input  wire logic [6:0]           reg_addr,
  input  wire logic                 reg_wr,
  input  wire logic [7:0]           reg_wdata,
  output logic      [7:0]           reg_rdata
);

  // ************************************************************
  // configuration
  // ************************************************************
  logic [7:0] config_a;
  logic [7:0] config_b;

  adm_cfg_regs u_cfg (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .reg_addr  (reg_addr),
    .reg_wr    (reg_wr),
    .reg_wdata (reg_wdata),
    .config_a  (config_a),
    .config_b  (config_b)
  );

  wire meas_en    = config_a[`ADM_A_ENABLE_BIT];
  wire use_iir    = config_a[`ADM_A_METHOD_BIT];
  wire hold       = config_b[`ADM_B_HOLD_BIT];
  wire latch_mode = config_b[`ADM_B_RESSEL_BIT];
  wire adm_pkg::adm_code_t len_code =
    config_a[`ADM_A_LEN_MSB:`ADM_A_LEN_LSB];
  wire adm_pkg::adm_code_t avg_code =
    config_b[`ADM_B_AVG_MSB:`ADM_B_AVG_LSB];
  // reserved length codes would give a zero or oversized span
  wire adm_pkg::adm_code_t len = adm_pkg::adm_len(len_code);
  // reserved period codes above twenty are clamped the same way
  wire adm_pkg::adm_code_t avg_n =
    (avg_code > `ADM_CODE_MAX) ? `ADM_CODE_MAX : avg_code;

  // ************************************************************
  // sinc averager
  // ************************************************************
  logic                 sinc_valid;
  adm_pkg::adm_sample_t sinc_out;

  wire sinc_clear = !meas_en || use_iir;

  adm_sinc u_sinc (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .clear     (sinc_clear),
    .in_valid  (sample_valid),
    .in_data   (sample_data),
    .len       (len),
    .out_valid (sinc_valid),
    .out_data  (sinc_out)
  );

  // ************************************************************
  // averaging period of the iir filter
  // ************************************************************
  logic [20:0] period_cnt;

  wire         iir_run    = meas_en && use_iir;
  wire         infinite   = avg_n == 5'h00;
  wire [20:0]  period_last = adm_pkg::adm_span_last(avg_n);
  wire         period_end = iir_run && !infinite &&
                            (period_cnt >= period_last);

  always_ff @(posedge mclk) begin
    // infinite mode parks the count so a later period starts afresh
    if (!reset_n || !iir_run || period_end || infinite) begin
      period_cnt <= 21'h0;
    end else begin
      period_cnt <= period_cnt + 21'h000001;
    end
  end

  // ************************************************************
  // first-order low-pass iir: y += (x - y) / 2^D
  // ************************************************************
  // 24 integer bits, 20 fraction bits and one guard bit
  logic signed [44:0] iir_y;
  logic signed [23:0] iir_latched;

  wire signed [44:0] x_ext   = {sample_data[23], sample_data, 20'h00000};
  wire adm_pkg::adm_wide_t diff = 46'(x_ext) - 46'(iir_y);
  wire adm_pkg::adm_wide_t step = adm_pkg::adm_ashr(diff, len);
  wire signed [44:0] next_iir_y = iir_y + step[44:0];
  wire signed [23:0] iir_out    = iir_y[43:20];

  always_ff @(posedge mclk) begin
    if (!reset_n || !iir_run || period_end) begin
      iir_y <= 45'h0;
    end else if (sample_valid) begin
      iir_y <= next_iir_y;
    end
  end

  // value caught the cycle before the filter is cleared
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      iir_latched <= 24'h000000;
    end else if (period_end) begin
      iir_latched <= iir_out;
    end
  end

  // ************************************************************
  // result and freeze
  // ************************************************************
  adm_pkg::adm_sample_t result;

  wire adm_pkg::adm_sample_t iir_pick =
    latch_mode ? iir_latched : iir_out;
  wire adm_pkg::adm_sample_t next_result =
    use_iir ? iir_pick : sinc_out;
  wire result_load = meas_en && !hold;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      result <= `ADM_RESULT_RESET;
    end else if (result_load) begin
      result <= next_result;
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  logic [7:0] next_rdata;

  always_comb begin
    case (reg_addr)
      `ADM_OFS_CONFIG_A: next_rdata = config_a;
      `ADM_OFS_CONFIG_B: next_rdata = config_b;
      `ADM_OFS_RES_HIGH: next_rdata = result[23:16];
      `ADM_OFS_RES_MID:  next_rdata = result[15:8];
      `ADM_OFS_RES_LOW:  next_rdata = result[7:0];
      default:           next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  property p_idle_when_off;
    @(posedge mclk) disable iff (!reset_n)
      !meas_en |=> (iir_y == 45'h0) && (period_cnt == 21'h0);
  endproperty
  a_idle_when_off: assert property (p_idle_when_off)
    else $error("filter not idle while measurement disabled");

  property p_sinc_block;
    @(posedge mclk) disable iff (!reset_n)
      (meas_en && !use_iir && len == 5'h01 && sample_valid
       && $stable(config_a)) ##1 (sample_valid && $stable(config_a))
      |=> sinc_valid || $past(sinc_valid);
  endproperty
  a_sinc_block: assert property (p_sinc_block)
    else $error("sinc average missing after two samples");

  property p_iir_step;
    @(posedge mclk) disable iff (!reset_n)
      (iir_run && sample_valid && !period_end)
      |=> iir_y == $past(iir_y) + $past(step[44:0]);
  endproperty
  a_iir_step: assert property (p_iir_step)
    else $error("iir state did not follow its update");

  property p_hold_freeze;
    @(posedge mclk) disable iff (!reset_n)
      hold [*2] |-> $stable(result);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze)
    else $error("result changed while held");

  property p_iir_instant;
    @(posedge mclk) disable iff (!reset_n)
      (meas_en && use_iir && !latch_mode && !hold)
      |=> result == $past(iir_out);
  endproperty
  a_iir_instant: assert property (p_iir_instant)
    else $error("result is not the instantaneous iir output");

  property p_latch_before_clear;
    @(posedge mclk) disable iff (!reset_n)
      period_end |=> (iir_latched == $past(iir_out)) && (iir_y == 45'h0);
  endproperty
  a_latch_before_clear: assert property (p_latch_before_clear)
    else $error("iir value not latched ahead of clear");

  property p_period_two;
    @(posedge mclk) disable iff (!reset_n)
      (period_end && avg_n == 5'h01 && iir_run)
      ##1 (iir_run && $stable(config_b) && $stable(config_a))
      |-> !period_end ##1 (period_end || !iir_run || !$stable(config_b));
  endproperty
  a_period_two: assert property (p_period_two)
    else $error("averaging period of two clocks not kept");

  property p_infinite;
    @(posedge mclk) disable iff (!reset_n)
      infinite |-> !period_end ##1 (period_cnt == 21'h0);
  endproperty
  a_infinite: assert property (p_infinite)
    else $error("periodic clear with infinite averaging");

  property p_read_high;
    @(posedge mclk) disable iff (!reset_n)
      reg_addr == `ADM_OFS_RES_HIGH |=> reg_rdata == $past(result[23:16]);
  endproperty
  a_read_high: assert property (p_read_high)
    else $error("high result byte read wrong");

  property p_read_mid;
    @(posedge mclk) disable iff (!reset_n)
      reg_addr == `ADM_OFS_RES_MID |=> reg_rdata == $past(result[15:8]);
  endproperty
  a_read_mid: assert property (p_read_mid)
    else $error("middle result byte read wrong");

  property p_read_low;
    @(posedge mclk) disable iff (!reset_n)
      reg_addr == `ADM_OFS_RES_LOW |=> reg_rdata == $past(result[7:0]);
  endproperty
  a_read_low: assert property (p_read_low)
    else $error("low result byte read wrong");

  property p_idle_result;
    @(posedge mclk) disable iff (!reset_n)
      !meas_en |=> $stable(result);
  endproperty
  a_idle_result: assert property (p_idle_result)
    else $error("result moved while measurement disabled");

  property p_sinc_off;
    @(posedge mclk) disable iff (!reset_n)
      sinc_clear |=> !sinc_valid;
  endproperty
  a_sinc_off: assert property (p_sinc_off)
    else $error("sinc averager active while not selected");

  property p_sinc_result;
    @(posedge mclk) disable iff (!reset_n)
      (meas_en && !use_iir && !hold) |=> result == $past(sinc_out);
  endproperty
  a_sinc_result: assert property (p_sinc_result)
    else $error("result is not the sinc average");

  property p_latched_result;
    @(posedge mclk) disable iff (!reset_n)
      (meas_en && use_iir && latch_mode && !hold)
      |=> result == $past(iir_latched);
  endproperty
  a_latched_result: assert property (p_latched_result)
    else $error("result is not the latched iir value");

  property p_latch_steady;
    @(posedge mclk) disable iff (!reset_n)
      !period_end |=> $stable(iir_latched);
  endproperty
  a_latch_steady: assert property (p_latch_steady)
    else $error("latched iir value moved between clears");

  property p_period_bound;
    @(posedge mclk) disable iff (!reset_n)
      (iir_run && !infinite && $stable(avg_n)) |-> period_cnt <= period_last;
  endproperty
  a_period_bound: assert property (p_period_bound)
    else $error("averaging period counter overran its span");

  property p_reset_clears;
    @(posedge mclk)
      !reset_n |=> (result == `ADM_RESULT_RESET) && (reg_rdata == 8'h00)
        && (config_a == `ADM_CONFIG_A_RESET)
        && (config_b == `ADM_CONFIG_B_RESET);
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("registers not cleared by reset");

  property p_write_a;
    @(posedge mclk) disable iff (!reset_n)
      (reg_wr && reg_addr == `ADM_OFS_CONFIG_A)
      |=> config_a == $past(reg_wdata);
  endproperty
  a_write_a: assert property (p_write_a)
    else $error("first configuration write not taken");

  property p_write_b;
    @(posedge mclk) disable iff (!reset_n)
      (reg_wr && reg_addr == `ADM_OFS_CONFIG_B)
      |=> config_b == $past(reg_wdata);
  endproperty
  a_write_b: assert property (p_write_b)
    else $error("second configuration write not taken");

endmodule
`default_nettype wire

// [pkg/adm_defines.svh]
// register offsets, field positions, reset values and limits of the dc level meter
`ifndef ADM_DEFINES_SVH
`define ADM_DEFINES_SVH

`define ADM_OFS_CONFIG_A   7'h66
`define ADM_OFS_CONFIG_B   7'h67
`define ADM_OFS_RES_HIGH   7'h68
`define ADM_OFS_RES_MID    7'h69
`define ADM_OFS_RES_LOW    7'h6a

`define ADM_CONFIG_A_RESET 8'h00
`define ADM_CONFIG_B_RESET 8'h00
`define ADM_RESULT_RESET   24'h000000

// config a fields
`define ADM_A_ENABLE_BIT   7
`define ADM_A_METHOD_BIT   5
`define ADM_A_LEN_MSB      4
`define ADM_A_LEN_LSB      0
// config b fields
`define ADM_B_HOLD_BIT     6
`define ADM_B_RESSEL_BIT   5
`define ADM_B_AVG_MSB      4
`define ADM_B_AVG_LSB      0

`define ADM_CODE_MIN       5'h01
`define ADM_CODE_MAX       5'h14

`endif

// [pkg/adm_pkg.sv]
// types and shared arithmetic of the dc level meter
`default_nettype none
`include "adm_defines.svh"
package adm_pkg;

  typedef logic signed [23:0] adm_sample_t;
  typedef logic signed [45:0] adm_wide_t;
  typedef logic [4:0]         adm_code_t;

  // reserved length codes are pulled into the legal range
  function automatic adm_code_t adm_len(input adm_code_t code);
    if (code < `ADM_CODE_MIN) begin
      return `ADM_CODE_MIN;
    end
    if (code > `ADM_CODE_MAX) begin
      return `ADM_CODE_MAX;
    end
    return code;
  endfunction

  function automatic adm_wide_t adm_ashr(input adm_wide_t v,
                                         input adm_code_t d);
    return v >>> d;
  endfunction

  function automatic logic [20:0] adm_span_last(input adm_code_t d);
    logic [20:0] one;
    one = 21'h000001;
    return (one << d) - 21'h000001;
  endfunction

endpackage
`default_nettype wire

// [rtl/adm_cfg_regs.sv]
// the two writable configuration registers of the dc level meter
`default_nettype none
`include "adm_defines.svh"
module adm_cfg_regs (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic [6:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] config_a,
  output logic      [7:0] config_b
);

  wire wr_a = reg_wr && (reg_addr == `ADM_OFS_CONFIG_A);
  wire wr_b = reg_wr && (reg_addr == `ADM_OFS_CONFIG_B);

  // reserved bits are stored as written so they read back
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      config_a <= `ADM_CONFIG_A_RESET;
      config_b <= `ADM_CONFIG_B_RESET;
    end else begin
      if (wr_a) begin
        config_a <= reg_wdata;
      end
      if (wr_b) begin
        config_b <= reg_wdata;
      end
    end
  end

endmodule
`default_nettype wire

// [rtl/adm_sinc.sv]
// first-order sinc averager over a power-of-two block of samples
`default_nettype none
module adm_sinc (
  input  wire logic                     mclk,
  input  wire logic                     reset_n,
  input  wire logic                     clear,
  input  wire logic                     in_valid,
  input  wire adm_pkg::adm_sample_t     in_data,
  input  wire adm_pkg::adm_code_t       len,
  output logic                          out_valid,
  output adm_pkg::adm_sample_t          out_data
);

  logic signed [43:0] acc;
  logic        [20:0] cnt;

  wire               last      = cnt == adm_pkg::adm_span_last(len);
  wire signed [43:0] in_ext    = 44'(in_data);
  wire signed [43:0] acc_sum   = acc + in_ext;
  wire adm_pkg::adm_wide_t avg = adm_pkg::adm_ashr(46'(acc_sum), len);

  always_ff @(posedge mclk) begin
    if (!reset_n || clear) begin
      acc       <= 44'h0;
      cnt       <= 21'h0;
      out_valid <= 1'b0;
    end else begin
      out_valid <= in_valid && last;
      if (in_valid) begin
        acc <= last ? 44'h0 : acc_sum;
        cnt <= last ? 21'h0 : cnt + 21'h000001;
      end
    end
  end

  // average persists through a clear so the last result stays readable
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      out_data <= 24'h000000;
    end else if (!clear && in_valid && last) begin
      out_data <= avg[23:0];
    end
  end

endmodule
`default_nettype wire

// [bench/adm_adc_src.sv]
// stand-in for the mono adc channel feeding the dc level meter
`default_nettype none
module adm_adc_src (
  input  wire logic                 mclk,
  input  wire logic                 slow,
  input  wire adm_pkg::adm_sample_t level,
  output logic                      sample_valid,
  output adm_pkg::adm_sample_t      sample_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] gap;

  initial begin
    gap = 2'h0;
    sample_valid = 1'b0;
    sample_data = 24'h000000;
  end

  // slow means one sample every third cycle, else every cycle
  // between strobes the data lines show the inverse, then the level again
  always @(posedge mclk) begin
    gap <= (gap == 2'h2 || !slow) ? 2'h0 : gap + 2'h1;
    sample_valid <= (gap == 2'h0);
    sample_data <= (gap == 2'h0) ? level : ~sample_data;
  end
endmodule
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench of the dc level meter
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] exp;
    logic [7:0] mask;
    logic       neq;
  } adm_note_t;

  logic                 mclk = 1'b0;
  logic                 reset_n = 1'b0;
  logic                 slow = 1'b0;
  logic                 rd_tick = 1'b0;
  logic [6:0]           reg_addr = 7'h00;
  logic                 reg_wr = 1'b0;
  logic [7:0]           reg_wdata = 8'h00;
  logic [7:0]           reg_rdata;
  logic                 sample_valid;
  adm_pkg::adm_sample_t sample_data;
  adm_pkg::adm_sample_t level = 24'h000000;
  adm_note_t            notes[$];
  adm_note_t            n;
  logic [7:0]           a;
  logic [7:0]           b;
  logic [31:0]          r;
  int                   fail_count = 0;
  int                   tests_run = 0;
  int                   seed = 32'h0df3;

  always #5 mclk = ~mclk;

  adm_dc_meas uut (
    .mclk(mclk), .reset_n(reset_n), .sample_valid(sample_valid),
    .sample_data(sample_data), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
  );
  adm_adc_src src (
    .mclk(mclk), .slow(slow), .level(level),
    .sample_valid(sample_valid), .sample_data(sample_data)
  );

  // ****************************************
  // bus tasks and comparison
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] ad, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // no read strobe: hold the offset two edges, then let the monitor look
  task automatic rd(input logic [6:0] ad, input logic [7:0] e,
                    input logic [7:0] m = 8'hff, input logic q = 1'b0);
    @(posedge mclk);
    reg_addr <= ad;
    notes.push_back('{e & m, m, q});
    repeat (2) @(posedge mclk);
    rd_tick <= 1'b1;
    @(posedge mclk);
    rd_tick <= 1'b0;
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    if (rd_tick) begin
      n = notes.pop_front();
      if (n.neq)
        check({7'h00, (reg_rdata & n.mask) !== n.exp}, 8'h01);
      else
        check(reg_rdata & n.mask, n.exp);
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(7'h65 + 7'(i), 8'h00);
    end
    // random setups while disabled: the result must stay at zero
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      a = {2'b00, r[5], 5'(r[15:8] % 8'd20 + 8'd1)};
      b = {1'b0, r[7:6], 5'(r[23:16] % 8'd21)};
      level <= r[31:8];
      slow <= r[0];
      wr(7'h66, a);
      wr(7'h67, b);
      wr(7'h68, r[7:0]);
      rd(7'h66, a);
      rd(7'h67, b);
      rd(7'h68, 8'h00);
      rd(7'h6a, 8'h00);
    end
    wr(7'h67, 8'h00);
    level <= 24'hedcbaa;
    wr(7'h66, 8'h82);
    repeat (60) @(posedge mclk);
    wr(7'h67, 8'h40);
    rd(7'h68, 8'hed);
    rd(7'h69, 8'hcb);
    rd(7'h6a, 8'haa);
    level <= 24'h0a0b0c;
    repeat (60) @(posedge mclk);
    rd(7'h68, 8'hed);
    wr(7'h67, 8'h00);
    repeat (60) @(posedge mclk);
    wr(7'h67, 8'h40);
    rd(7'h68, 8'h0a);
    rd(7'h69, 8'h0b);
    rd(7'h6a, 8'h0c);
    // iir with d = 1 settles within one lsb of the input
    slow <= 1'b0;
    level <= 24'h012342;
    wr(7'h67, 8'h00);
    wr(7'h66, 8'ha1);
    repeat (200) @(posedge mclk);
    wr(7'h67, 8'h40);
    rd(7'h68, 8'h01);
    rd(7'h69, 8'h23);
    rd(7'h6a, 8'h40, 8'hfc);
    // clearing every 2 cycles keeps the output well short of the input
    level <= 24'h7ffff0;
    wr(7'h67, 8'h01);
    repeat (200) @(posedge mclk);
    wr(7'h67, 8'h41);
    rd(7'h68, 8'h7f, 8'hff, 1'b1);
    wr(7'h67, 8'h22);
    repeat (100) @(posedge mclk);
    wr(7'h67, 8'h62);
    // three updates per period of four: seven eighths of the input
    rd(7'h68, 8'h6f);
    rd(7'h69, 8'hff);
    rd(7'h6a, 8'hf2);
    // a reset in mid-run drops the result and the settings
    reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    rd(7'h68, 8'h00);
    rd(7'h67, 8'h00);
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
